/* hw/cblat_addr_term.sv */
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`default_nettype none
// What this block does
// R1 - narrow single transfers one beat, dword two
// R2 - narrow mode uses only upper data half
// R3 - lanes from two low address bits
// R4 - word-crossing access split into two accesses
// R5 - offset 3 word: byte then three bytes
// R6 - end every address tenure with acknowledge
// R7 - retry sampled in cycle after acknowledge
// R8 - snoop source depends on initiator
// R9 - hitting processor requests bus after window
// R10 - repeat retried snoop while enable set
// R11 - assert retry for castout or pci busy
// R12 - grant bus to retrying requesting processor
// R13 - wait at least address wait states
// R14 - no pipelined ack until data tenure ends
// R15 - hold ack until no retry can arise
// R16 - aphase waits at least cache hit delay; not done, the CFG_L2HIT_LSB field is never used
// R17 - aphase waits at least snoop waits
// R18 - snoop waits gate device tenure acknowledge
// R19 - 1:1 processors need one snoop wait
// R20 - burst low address bits driven zero
// R21 - lower data half ignored in narrow mode
module cblat_addr_term
(
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        resetn,
  // wishbone slave
  input  wire  logic        wb_cyc_i,
  input  wire  logic        wb_stb_i,
  input  wire  logic        wb_we_i,
  input  wire  logic [7:0]  wb_adr_i,
  input  wire  logic [3:0]  wb_sel_i,
  input  wire  logic [31:0] wb_dat_i,
  output logic       [31:0] wb_dat_o,
  output logic              wb_ack_o,
  // processor address tenure
  input  wire  logic        ts_i,
  input  wire  logic        pipelined_i,
  input  wire  logic        data_busy_i,
  input  wire  logic        pci_busy_i,
  input  wire  logic        burst_i,
  input  wire  logic [2:0]  transfer_size_code,
  input  wire  logic [2:0]  low_address_bits,
  input  wire  logic [1:0]  bus_request_line,
  // snoop response and retry pin
  input  wire  logic        address_retry_i,
  output logic              address_retry_o,
  output logic              address_retry_oe_n,
  // acknowledge, grant, lanes
  output logic              aack_o,
  output logic [1:0]        bus_grant_o,
  output logic [3:0]        lane_en_o,
  output logic [1:0]        beats_o,
  output logic              split_o,
  output logic [2:0]        addr_out_o,
  output logic              lower_half_en_o,
  output logic              snoop_busy_o
);
  cblat_pkg::cblat_state_e state_ff, nxt_state;
  logic [31:0]             cfg_ff;
  logic                    snp_go_ff;
  logic                    cast_ff;
  logic                    dev_ff;
  logic [cblat_pkg::WS_W-1:0] cnt_ff;
  logic [cblat_pkg::WS_W-1:0] ws_need;
  logic                    retried_ff;
  logic [1:0]              req_ff;
  logic [31:0]             retry_cnt_ff;
  logic                    wb_hit;
  logic                    retry_cond;
  cblat_pkg::cblat_xfer_s  xfer;
  cblat_pkg::cblat_steer_s steer;

  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // wishbone: single wait state answer, ack for one cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_hit;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cfg_ff <= cblat_pkg::CFG_RESET;
    else if (wb_hit && wb_we_i && wb_adr_i == cblat_pkg::ADDR_CFG)
    begin
      for (int i = 0; i < 4; i++)
        if (wb_sel_i[i])
          cfg_ff[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
    end
  end

  // snoop launch: software write, cleared in its device tenure's window unless retried with the repeat bit on
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      snp_go_ff <= 1'b0;
      cast_ff   <= 1'b0;
    end
    else
    begin
      if (state_ff == cblat_pkg::ST_WINDOW && dev_ff)
      begin
        // repeat only while retried and the repeat bit is on
        if (!(address_retry_i && cfg_ff[cblat_pkg::CFG_REPEAT_BIT]))
          snp_go_ff <= 1'b0; // R10
      end
      // cast-out stays pending through the window so its retry is really driven
      if (state_ff == cblat_pkg::ST_WINDOW && !dev_ff)
        cast_ff <= 1'b0;
      // a software set in the same cycle as a clear wins
      if (wb_hit && wb_we_i && wb_adr_i == cblat_pkg::ADDR_SNOOP && wb_sel_i[0])
      begin
        if (wb_dat_i[cblat_pkg::SNP_GO_BIT])
          snp_go_ff <= 1'b1;
        if (wb_dat_i[cblat_pkg::SNP_CAST_BIT])
          cast_ff <= 1'b1; // R11
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wb_dat_o <= cblat_pkg::RD_UNMAPPED;
    else if (wb_hit && !wb_we_i)
    begin
      case (wb_adr_i)
        cblat_pkg::ADDR_CFG:    wb_dat_o <= cfg_ff;
        cblat_pkg::ADDR_STATUS: wb_dat_o <= {retry_cnt_ff[23:0], 3'h0, retried_ff,
                                             1'b0, 3'(state_ff)};
        cblat_pkg::ADDR_SNOOP:  wb_dat_o <= {30'h0, cast_ff, snp_go_ff};
        default:                wb_dat_o <= cblat_pkg::RD_UNMAPPED;
      endcase
    end
  end

  // lane steering for the narrow data path
  assign xfer.size_code = transfer_size_code;
  assign xfer.low_addr  = low_address_bits;

  cblat_lane_steer u_steer
  (
    .req   (xfer),
    .steer (steer)
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lane_en_o  <= cblat_pkg::LANES_NONE;
      beats_o    <= cblat_pkg::BEATS_ONE;
      split_o    <= 1'b0;
      addr_out_o <= cblat_pkg::BURST_LOW;
    end
    else if (ts_i && state_ff == cblat_pkg::ST_IDLE)
    begin
      lane_en_o  <= steer.lane_en; // R3 R4
      beats_o    <= steer.beats; // R1
      split_o    <= steer.split; // R5
      addr_out_o <= burst_i ? cblat_pkg::BURST_LOW : steer.first.low_addr; // R20
    end
  end

  // lower half never carries data in narrow mode
  assign lower_half_en_o = ~cfg_ff[cblat_pkg::CFG_NARROW_BIT]; // R2 R21

  // wait-state target: processor tenures take the larger of aphase and snoop
  always_comb
  begin
    if (dev_ff)
      ws_need = cfg_ff[cblat_pkg::CFG_SNOOP_LSB +: cblat_pkg::WS_W]; // R18
    else if (cfg_ff[cblat_pkg::CFG_APHASE_LSB +: cblat_pkg::WS_W] >
             cfg_ff[cblat_pkg::CFG_SNOOP_LSB +: cblat_pkg::WS_W])
      ws_need = cfg_ff[cblat_pkg::CFG_APHASE_LSB +: cblat_pkg::WS_W]; // R13
    else
      // guards against software leaving aphase below the snoop setting
      ws_need = cfg_ff[cblat_pkg::CFG_SNOOP_LSB +: cblat_pkg::WS_W]; // R17
  end

  assign retry_cond = cast_ff | pci_busy_i; // R11

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      cblat_pkg::ST_IDLE:
        if (ts_i || snp_go_ff)
          nxt_state = cblat_pkg::ST_WAIT;
      cblat_pkg::ST_WAIT:
        // ack held for waits, open data tenure of a pipelined tenure, pending retry cause while data busy
        if (cnt_ff >= ws_need && !(pipelined_i && data_busy_i) // R13 R14
            && !(retry_cond && !dev_ff && data_busy_i)) // R15
          nxt_state = cblat_pkg::ST_ACK;
      cblat_pkg::ST_ACK:
        nxt_state = cblat_pkg::ST_WINDOW;
      cblat_pkg::ST_WINDOW:
        nxt_state = cblat_pkg::ST_OPP;
      cblat_pkg::ST_OPP:
        nxt_state = cblat_pkg::ST_IDLE;
      default:
        nxt_state = cblat_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_ff <= cblat_pkg::ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_ff <= '0;
      dev_ff <= 1'b0;
    end
    else if (state_ff == cblat_pkg::ST_IDLE)
    begin
      cnt_ff <= '0;
      dev_ff <= ~ts_i & snp_go_ff;
    end
    else if (state_ff == cblat_pkg::ST_WAIT && cnt_ff != '1)
      cnt_ff <= cnt_ff + 1'b1;
  end

  assign aack_o = (state_ff == cblat_pkg::ST_ACK); // R6

  // device drives retry only in the window of a processor tenure
  assign address_retry_o    = 1'b1;
  assign address_retry_oe_n = ~(state_ff == cblat_pkg::ST_WINDOW && !dev_ff && retry_cond);

  // window sampling: retry from any snooper; the hitting master's request one cycle later
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      retried_ff   <= 1'b0;
      req_ff       <= 2'b00;
      retry_cnt_ff <= 32'h0000_0000;
    end
    else if (state_ff == cblat_pkg::ST_WINDOW)
    begin
      retried_ff <= address_retry_i; // R7 R8
      if (address_retry_i)
        retry_cnt_ff <= retry_cnt_ff + 32'h0000_0001;
    end
    else if (state_ff == cblat_pkg::ST_OPP)
      req_ff <= bus_request_line; // R9
  end

  // copy-back grant to the processor that retried and asked for the bus
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      bus_grant_o <= 2'b00;
    else if (state_ff == cblat_pkg::ST_OPP && retried_ff)
      bus_grant_o <= bus_request_line[0] ? 2'b01 : (bus_request_line[1] ? 2'b10 : 2'b00); // R12
    else if (bus_request_line == 2'b00)
      bus_grant_o <= 2'b00;
  end

  assign snoop_busy_o = snp_go_ff;

  property p_ack_one;
    @(posedge clk) disable iff (!resetn) aack_o |=> !aack_o ##1 !aack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle"); // R6

  property p_wait_min;
    @(posedge clk) disable iff (!resetn)
      aack_o |-> $past(cnt_ff) >= $past(ws_need);
  endproperty
  a_wait_min: assert property (p_wait_min) else $error("ack before wait states"); // R13

  property p_pipe;
    @(posedge clk) disable iff (!resetn)
      aack_o |-> !($past(pipelined_i) && $past(data_busy_i));
  endproperty
  a_pipe: assert property (p_pipe) else $error("ack during open data tenure"); // R14

  property p_win;
    @(posedge clk) disable iff (!resetn)
      !address_retry_oe_n |-> $past(aack_o);
  endproperty
  a_win: assert property (p_win) else $error("retry outside window"); // R7

  property p_grant;
    @(posedge clk) disable iff (!resetn)
      (state_ff == cblat_pkg::ST_OPP && retried_ff && bus_request_line[0]) |=> bus_grant_o[0];
  endproperty
  a_grant: assert property (p_grant) else $error("no copy-back grant"); // R12

  property p_narrow;
    @(posedge clk) disable iff (!resetn)
      cfg_ff[cblat_pkg::CFG_NARROW_BIT] |-> !lower_half_en_o;
  endproperty
  a_narrow: assert property (p_narrow) else $error("lower half used"); // R2

  property p_burst0;
    @(posedge clk) disable iff (!resetn)
      (ts_i && burst_i && state_ff == cblat_pkg::ST_IDLE) |=> addr_out_o == 3'h0;
  endproperty
  a_burst0: assert property (p_burst0) else $error("burst address not zero"); // R20

  property p_dw;
    @(posedge clk) disable iff (!resetn)
      (ts_i && state_ff == cblat_pkg::ST_IDLE && transfer_size_code == 3'h0)
        |=> beats_o == 2'h2 && lane_en_o == 4'hf;
  endproperty
  a_dw: assert property (p_dw) else $error("double word steering wrong"); // R1

  property p_seq;
    @(posedge clk) disable iff (!resetn)
      aack_o |=> state_ff == cblat_pkg::ST_WINDOW ##1 state_ff == cblat_pkg::ST_OPP;
  endproperty
  a_seq: assert property (p_seq) else $error("window order broken"); // R9

  c_ack: cover property (@(posedge clk) disable iff (!resetn) aack_o);
  c_retry: cover property (@(posedge clk) disable iff (!resetn) !address_retry_oe_n);
  c_split: cover property (@(posedge clk) disable iff (!resetn) split_o);
  c_repeat: cover property (@(posedge clk) disable iff (!resetn)
    dev_ff && state_ff == cblat_pkg::ST_WINDOW && address_retry_i);
endmodule : cblat_addr_term
`default_nettype wire

/* inc/cblat_pkg.sv */
`default_nettype none
package cblat_pkg;

  // wishbone register map (byte addresses)
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SNOOP  = 8'h08;

  // config register fields
  localparam int CFG_APHASE_LSB = 0;
  localparam int CFG_SNOOP_LSB  = 4;
  localparam int CFG_L2HIT_LSB  = 8;
  localparam int CFG_REPEAT_BIT = 12;
  localparam int CFG_NARROW_BIT = 13;
  localparam int WS_W           = 4;
  localparam logic [31:0] CFG_RESET = 32'h0000_2011;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // snoop control register fields
  localparam int SNP_GO_BIT  = 0;
  localparam int SNP_CAST_BIT = 1;

  // transfer size codes
  localparam logic [2:0] TSZ_DWORD = 3'h0;
  localparam logic [2:0] TSZ_BYTE  = 3'h1;
  localparam logic [2:0] TSZ_HALF  = 3'h2;
  localparam logic [2:0] TSZ_THREE = 3'h3;
  localparam logic [2:0] TSZ_WORD  = 3'h4;
  localparam logic [2:0] BURST_LOW = 3'h0;
  localparam logic [2:0] WORD_HI   = 3'h4;

  localparam logic [3:0] LANES_NONE = 4'h0;
  localparam logic [3:0] LANES_ALL  = 4'hf;

  localparam logic [1:0] BEATS_ONE = 2'h1;
  localparam logic [1:0] BEATS_TWO = 2'h2;

  typedef struct packed {
    logic [2:0] size_code;
    logic [2:0] low_addr;
  } cblat_xfer_s;

  typedef struct packed {
    logic [3:0] lane_en;
    logic [1:0] beats;
    logic       split;
    cblat_xfer_s first;
    cblat_xfer_s second;
  } cblat_steer_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_ACK,
    ST_WINDOW,
    ST_OPP
  } cblat_state_e;

endpackage : cblat_pkg
`default_nettype wire

/* hw/cblat_lane_steer.sv */
`default_nettype none
module cblat_lane_steer
(
  // request
  input  wire  cblat_pkg::cblat_xfer_s  req,
  // steering result
  output var   cblat_pkg::cblat_steer_s steer
);
  logic [2:0] nbytes;
  logic [2:0] end_off;
  logic [2:0] first_n;
  logic [2:0] rest_n;
  logic [3:0] mask;

  always_comb
  begin
    nbytes = (req.size_code == cblat_pkg::TSZ_DWORD) ? cblat_pkg::TSZ_WORD : req.size_code;
    end_off = {1'b0, req.low_addr[1:0]} + nbytes;
    first_n = 3'(cblat_pkg::TSZ_WORD - {1'b0, req.low_addr[1:0]});
    rest_n = 3'(end_off - cblat_pkg::TSZ_WORD);
    steer = '0;
    steer.first = req;
    steer.beats = cblat_pkg::BEATS_ONE; // R1
    mask = 4'((5'h1 << nbytes) - 5'h1);
    // lane index ignores the top address bit; only lanes 0-3 exist
    steer.lane_en = 4'(mask << req.low_addr[1:0]); // R3 R2
    if (req.size_code == cblat_pkg::TSZ_DWORD)
    begin
      steer.lane_en = cblat_pkg::LANES_ALL; // R1
      steer.beats = cblat_pkg::BEATS_TWO;
      steer.first.low_addr = cblat_pkg::BURST_LOW;
    end
    else if (end_off > cblat_pkg::TSZ_WORD)
    begin
      // crossing a word boundary: two accesses, first up to the boundary
      steer.split = 1'b1; // R4 R5
      steer.first.size_code = first_n;
      steer.lane_en = 4'(cblat_pkg::LANES_ALL << req.low_addr[1:0]);
      steer.second.size_code = rest_n;
      steer.second.low_addr = {~req.low_addr[2], 2'b00};
    end
  end
endmodule : cblat_lane_steer
`default_nettype wire

/* bench/cblat_proc_model.sv */
`default_nettype none
module cblat_proc_model
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // device side
  input  wire logic       aack_o,
  input  wire logic [1:0] bus_grant_o,
  // scenario control
  input  wire logic       load,
  input  wire logic [3:0] hits,
  input  wire logic [1:0] who,
  // snoop response
  output logic            retry,
  output logic [1:0]      br
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       win_ff;
  logic [3:0] cnt_ff;

  // retry may only come in the cycle right after acknowledge
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) win_ff <= 1'b0;
    else win_ff <= aack_o;
  // other processor or cache retries the next hits tenures, either initiator
  assign retry = win_ff && (cnt_ff != 4'h0);
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) cnt_ff <= 4'h0;
    else if (load) cnt_ff <= hits;
    else if (retry) cnt_ff <= cnt_ff - 4'h1;
  // request in the cycle after the window, held until granted
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) br <= 2'h0;
    else if (load) br <= 2'h0;
    else if (retry) br <= who;
    else br <= br & ~bus_grant_o;
endmodule : cblat_proc_model
`default_nettype wire

/* bench/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ts_i, pipelined_i;
  logic        data_busy_i, pci_busy_i, burst_i, address_retry_i, address_retry_o;
  logic        address_retry_oe_n, aack_o, split_o, lower_half_en_o, snoop_busy_o;
  logic        load, m_retry;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, lane_en_o, hits;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [2:0]  transfer_size_code, low_address_bits, addr_out_o;
  logic [1:0]  bus_request_line, bus_grant_o, beats_o, who, gseen;
  int          n_mismatch, total_checks, lat, nack;
  localparam logic [10:0] TAB [14] = '{{3'd2, 3'd0, 4'h3, 1'b0}, {3'd2, 3'd2, 4'hc, 1'b0},
    {3'd2, 3'd4, 4'h3, 1'b0}, {3'd2, 3'd6, 4'hc, 1'b0}, {3'd2, 3'd3, 4'h8, 1'b1},
    {3'd4, 3'd0, 4'hf, 1'b0}, {3'd4, 3'd4, 4'hf, 1'b0}, {3'd4, 3'd1, 4'he, 1'b1},
    {3'd4, 3'd2, 4'hc, 1'b1}, {3'd4, 3'd3, 4'h8, 1'b1}, {3'd4, 3'd5, 4'he, 1'b1},
    {3'd3, 3'd1, 4'he, 1'b0}, {3'd3, 3'd4, 4'h7, 1'b0}, {3'd0, 3'd0, 4'hf, 1'b0}};

  // retry wire: processor model retry ORed with the device drive when enabled, otherwise inactive
  assign address_retry_i = m_retry | (~address_retry_oe_n & address_retry_o);

  cblat_addr_term i_cblat_addr_term (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ts_i, .pipelined_i,
    .data_busy_i, .pci_busy_i, .burst_i, .transfer_size_code, .low_address_bits,
    .bus_request_line, .address_retry_i, .address_retry_o, .address_retry_oe_n, .aack_o,
    .bus_grant_o, .lane_en_o, .beats_o, .split_o, .addr_out_o, .lower_half_en_o,
    .snoop_busy_o);
  cblat_proc_model i_cblat_proc_model (.clk, .resetn, .aack_o, .bus_grant_o, .load,
    .hits, .who, .retry(m_retry), .br(bus_request_line));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (aack_o === 1'b1) nack <= nack + 1;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, s);
      n_mismatch++;
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    n = 0;
    do @(posedge clk); while (wb_ack_o !== 1'b1 && ++n < 100);
    q = wb_dat_o;
    chk("wb ack", 1'b1, wb_ack_o);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb

  task automatic ten(input logic [2:0] sz, a, input logic b, input logic [3:0] ln,
                     input logic sp);
    @(posedge clk);
    {ts_i, transfer_size_code, low_address_bits, burst_i} <= {1'b1, sz, a, b};
    @(posedge clk);
    ts_i <= 1'b0;
    #1;
    chk("lanes", ln, lane_en_o);
    chk("split", sp, split_o);
    chk("addr out", b ? 3'h0 : a, addr_out_o);
    if (!b) chk("beats", (sz == cblat_pkg::TSZ_DWORD) ? 2'h2 : 2'h1, beats_o);
    lat = 0;
    while (aack_o !== 1'b1 && lat < 300)
    begin
      @(posedge clk);
      #1;
      lat++;
    end
    @(posedge clk);
    #1;
    q[0] = address_retry_oe_n;
    repeat (2) @(posedge clk);
  endtask : ten

  task automatic arm(input logic [3:0] h, input logic [1:0] w);
    @(posedge clk);
    {load, hits, who} <= {1'b1, h, w};
    @(posedge clk);
    load <= 1'b0;
  endtask : arm

  task automatic dev_snoop(input logic [31:0] cfg, input int exp);
    int n;
    int n0;
    wb(1'b1, cblat_pkg::ADDR_CFG, cfg);
    arm(4'h2, 2'h0);
    n0 = nack;
    wb(1'b1, cblat_pkg::ADDR_SNOOP, 32'h0000_0001);
    repeat (3) @(posedge clk);
    n = 0;
    while (snoop_busy_o !== 1'b0 && n++ < 400) @(posedge clk);
    repeat (4) @(posedge clk);
    chk("snoop busy", 1'b0, snoop_busy_o);
    chk("snoop count", exp, nack - n0);
  endtask : dev_snoop

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  initial
  begin
    #200us;
    n_mismatch++;
    final_report;
  end

  initial
  begin
    {resetn, wb_cyc_i, wb_stb_i, wb_we_i, ts_i, pipelined_i, data_busy_i} = 7'h0;
    {pci_busy_i, burst_i, load, wb_adr_i, hits, who, wb_dat_i} = 0;
    {transfer_size_code, low_address_bits, gseen} = 0;
    wb_sel_i = 4'hf;
    {n_mismatch, total_checks} = 0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    wb(1'b0, cblat_pkg::ADDR_CFG, 32'h0);
    chk("cfg reset", cblat_pkg::CFG_RESET, q);
    wb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", cblat_pkg::RD_UNMAPPED, q);
    chk("lower half", 1'b0, lower_half_en_o);
    for (int i = 0; i < 8; i++)
    begin
      ten(cblat_pkg::TSZ_BYTE, i[2:0], 1'b0, 4'h1 << i[1:0], 1'b0);
      chk("latency", 2, lat);
    end
    for (int i = 0; i < 14; i++)
    begin
      ten(TAB[i][10:8], TAB[i][7:5], 1'b0, TAB[i][4:1], TAB[i][0]);
      chk("latency", 2, lat);
    end
    ten(cblat_pkg::TSZ_WORD, 3'h4, 1'b1, 4'hf, 1'b0);
    // wait state fields: processor waits for the larger of the two
    wb(1'b1, cblat_pkg::ADDR_CFG, 32'h0000_2323);
    wb(1'b0, cblat_pkg::ADDR_CFG, 32'h0);
    chk("cfg rw", 32'h0000_2323, q);
    ten(cblat_pkg::TSZ_WORD, 3'h0, 1'b0, 4'hf, 1'b0);
    chk("latency", 4, lat);
    wb(1'b1, cblat_pkg::ADDR_CFG, 32'h0000_2040);
    ten(cblat_pkg::TSZ_WORD, 3'h0, 1'b0, 4'hf, 1'b0);
    chk("latency", 5, lat);
    wb(1'b1, cblat_pkg::ADDR_CFG, 32'h0000_0011);
    @(posedge clk);
    chk("lower half", 1'b1, lower_half_en_o);
    wb(1'b1, cblat_pkg::ADDR_CFG, cblat_pkg::CFG_RESET);
    // pipelined tenure is held while the data tenure stays open
    {pipelined_i, data_busy_i} <= 2'b11;
    fork
      begin
        repeat (12) @(posedge clk);
        data_busy_i <= 1'b0;
      end
    join_none
    ten(cblat_pkg::TSZ_WORD, 3'h0, 1'b0, 4'hf, 1'b0);
    chk("pipelined", 1'b1, lat > 10 && lat < 16);
    pipelined_i <= 1'b0;
    wb(1'b1, cblat_pkg::ADDR_SNOOP, 32'h0000_0002);
    // a pending cast-out with an open data tenure holds the acknowledge
    data_busy_i <= 1'b1;
    fork
      begin
        repeat (8) @(posedge clk);
        data_busy_i <= 1'b0;
      end
    join_none
    ten(cblat_pkg::TSZ_WORD, 3'h0, 1'b0, 4'hf, 1'b0);
    chk("retry hold", 1'b1, lat > 5 && lat < 10);
    chk("castout retry", 1'b0, q[0]);
    pci_busy_i <= 1'b1;
    ten(cblat_pkg::TSZ_WORD, 3'h0, 1'b0, 4'hf, 1'b0);
    chk("pci retry", 1'b0, q[0]);
    wb(1'b0, cblat_pkg::ADDR_STATUS, 32'h0);
    chk("status", {24'h00_0002, 3'h0, 1'b1, 1'b0, 3'(cblat_pkg::ST_IDLE)}, q);
    pci_busy_i <= 1'b0;
    ten(cblat_pkg::TSZ_WORD, 3'h0, 1'b0, 4'hf, 1'b0);
    chk("no retry", 1'b1, q[0]);
    for (int i = 1; i < 4; i++)
    begin
      arm(4'h1, i[1:0]);
      gseen = 2'h0;
      ten(cblat_pkg::TSZ_WORD, 3'h0, 1'b0, 4'hf, 1'b0);
      repeat (3)
      begin
        @(posedge clk);
        #1;
        gseen = gseen | bus_grant_o;
      end
      chk("grant", (i == 2) ? 2'h2 : 2'h1, gseen);
    end
    dev_snoop(32'h0000_3011, 3);
    dev_snoop(cblat_pkg::CFG_RESET, 1);
    arm(4'h0, 2'h0);
    final_report;
  end
endmodule : testbench
`default_nettype wire
